/* logic/bpf_defines.vh */
`ifndef BPF_DEFINES_VH
`define BPF_DEFINES_VH

// typical delays in microseconds, then clock in MHz and shorten divider
`define BPF_OC_DET_US      1000
`define BPF_OC_REL_US      1000
`define BPF_OD_DET_US      100000
`define BPF_OD_REL_US      1000
`define BPF_CUR_DET_US     5000
`define BPF_CUR_REL_US     1000
`define BPF_SC_DET_US      500
`define BPF_XC_DET_US      1500
`define BPF_XC_REL_US      1500
`define BPF_CLK_MHZ        125
`define BPF_SHORT_DIV      64

// register map, word byte addresses
`define BPF_ADDR_CTRL      4'h0
`define BPF_ADDR_STATUS    4'h4
`define BPF_ADDR_INPUTS    4'h8
`define BPF_ADDR_ID        4'hc
`define BPF_ID_VALUE       32'h0000b10c

// status bit positions
`define BPF_ST_CHG_GATE    0
`define BPF_ST_DSG_GATE    1
`define BPF_ST_OC          2
`define BPF_ST_OD          3
`define BPF_ST_CUR         4
`define BPF_ST_SC          5
`define BPF_ST_XC          6
`define BPF_ST_STBY        7
`define BPF_ST_PULL_VDD    8
`define BPF_ST_PULL_VSS    9
`define BPF_ST_SHORTEN     10

// control bit positions
`define BPF_CT_SHORTEN     0

`endif

/* logic/bpf_protect.v */
// Operation
// R1: over-charge, after delay, charge gate low
// R2: load after over-charge cancels big hysteresis
// R3: over-charge suppresses over-current, not short
// R4: both cells released, load ok, charge gate high
// R5: high node without load attached holds charge gate low
// R6: excessive-charger check after over-charge release
// R7: over-discharge, after delay, discharge gate low
// R8: over-discharge enters stand-by, pull to supply
// R9: stand-by left only when charger pulls node
// R10: cells recovered, delayed discharge gate high
// R11: over-current, after delay, discharge gate low
// R12: over-current selects ground pull, no stand-by
// R13: short circuit, short delay, discharge gate low
// R14: short circuit selects ground pull, no stand-by
// R15: node low again releases over-current/short
// R16: excessive charger, after delay, charge gate low
// R17: excessive charger gone early, detection abandoned
// R18: excessive charger gone, delayed charge gate high
// R19: no excessive-charger check while discharge low
// R20: zero-volt cell charging enables charge gate
// R21: shorten input divides counter delays
// R22: short-circuit delay ignores shorten input
// R23: over-discharge delays 100 ms and 1.0 ms
// R24: over-current 5.0 ms, short 0.5 ms
// R25: counters restart when condition drops
// R26: shorten division ratio is a parameter
`timescale 1ns/10ps
`default_nettype none
`include "bpf_defines.vh"

module bpf_protect #(
	parameter SHORT_DIV = `BPF_SHORT_DIV,
	parameter CLK_MHZ   = `BPF_CLK_MHZ,
	parameter OC_DET    = `BPF_OC_DET_US * `BPF_CLK_MHZ,
	parameter OC_REL    = `BPF_OC_REL_US * `BPF_CLK_MHZ,
	parameter OD_DET    = `BPF_OD_DET_US * `BPF_CLK_MHZ,
	parameter OD_REL    = `BPF_OD_REL_US * `BPF_CLK_MHZ,
	parameter CUR_DET   = `BPF_CUR_DET_US * `BPF_CLK_MHZ,
	parameter CUR_REL   = `BPF_CUR_REL_US * `BPF_CLK_MHZ,
	parameter SC_DET    = `BPF_SC_DET_US * `BPF_CLK_MHZ,
	parameter XC_DET    = `BPF_XC_DET_US * `BPF_CLK_MHZ,
	parameter XC_REL    = `BPF_XC_REL_US * `BPF_CLK_MHZ
) (
	input  wire        core_clk,
	input  wire        rst,
	input  wire [1:0]  cell_overcharge,
	input  wire [1:0]  cell_oc_release,
	input  wire [1:0]  cell_overdischarge,
	input  wire        load_node_level,
	input  wire        load_attached,
	input  wire        overcurrent_threshold,
	input  wire        short_circuit,
	input  wire        excess_charger,
	input  wire        standby_release,
	input  wire        zero_volt_ok,
	input  wire        shorten_pin,
	input  wire [3:0]  avs_address,
	input  wire        avs_read,
	input  wire        avs_write,
	input  wire [31:0] avs_writedata,
	output reg  [31:0] avs_readdata,
	output wire        avs_waitrequest,
	output reg         charge_gate,
	output reg         discharge_gate,
	output reg         pull_to_vdd,
	output reg         pull_to_vss,
	output reg         standby,
	output reg         hyst_cancel
);

	localparam CW = 24;

	// synchronisers: stage one is read only by stage two
	localparam NS = 14;
	wire [NS-1:0] raw_in = {cell_overcharge, cell_oc_release,
		cell_overdischarge, load_node_level, load_attached,
		overcurrent_threshold, short_circuit, excess_charger,
		standby_release, zero_volt_ok, shorten_pin};
	reg  [NS-1:0] sync1;
	reg  [NS-1:0] sync2;
	always @(posedge core_clk or posedge rst) begin
		if (rst) begin
			sync1 <= {NS{1'b0}};
			sync2 <= {NS{1'b0}};
		end else begin
			sync1 <= raw_in;
			sync2 <= sync1;
		end
	end

	wire [1:0] s_ovc  = sync2[13:12];
	wire [1:0] s_rel  = sync2[11:10];
	wire [1:0] s_ovd  = sync2[9:8];
	wire       s_node = sync2[7];
	wire       s_load = sync2[6];
	wire       s_cur  = sync2[5];
	wire       s_sc   = sync2[4];
	wire       s_xc   = sync2[3];
	wire       s_stbr = sync2[2];
	wire       s_zero = sync2[1];
	wire       s_pin  = sync2[0];

	reg  ctrl_shorten;
	wire shorten = s_pin | ctrl_shorten;

	// terminal count, divided in shorten mode
	function [CW-1:0] term;
		input [CW-1:0] full;
		input          sh;
		reg   [CW-1:0] q;
		begin
			q = full / SHORT_DIV[CW-1:0];
			if (!sh)
				term = full;
			else if (q == {CW{1'b0}})
				term = {{(CW-1){1'b0}}, 1'b1};
			else
				term = q;
		end
	endfunction

	// states
	reg oc_st;
	reg od_st;
	reg cur_st;
	reg sc_st;
	reg xc_st;
	reg zero_armed;

	// conditions driving each timer
	wire any_ovc  = |s_ovc;
	wire both_rel = &s_rel;
	wire rel_ok   = both_rel & (~s_node | s_load);     // R4 R5
	wire any_ovd  = |s_ovd;
	wire ovd_clr  = ~any_ovd;
	wire xc_eval  = discharge_gate & ~oc_st;           // R6 R19

	localparam NT = 9;
	wire [NT-1:0] cond;
	assign cond[0] = ~oc_st & any_ovc;                              // R1
	assign cond[1] = oc_st & rel_ok;                                // R4
	assign cond[2] = ~od_st & ~oc_st & any_ovd;                     // R7
	assign cond[3] = od_st & ~standby & ovd_clr;                    // R10
	assign cond[4] = ~cur_st & ~oc_st & ~od_st & ~sc_st & s_cur;    // R3 R11
	// a shorted node is above the over-current level as well
	assign cond[5] = (cur_st | sc_st) & ~s_cur & ~s_sc;             // R15
	assign cond[6] = ~sc_st & ~od_st & s_sc;                        // R13
	assign cond[7] = ~xc_st & xc_eval & s_xc;                       // R16
	assign cond[8] = xc_st & ~s_xc;                                 // R18

	wire [CW-1:0] full [0:NT-1];
	assign full[0] = OC_DET[CW-1:0];
	assign full[1] = OC_REL[CW-1:0];
	assign full[2] = OD_DET[CW-1:0];                    // R23
	assign full[3] = OD_REL[CW-1:0];                    // R23
	assign full[4] = CUR_DET[CW-1:0];                   // R24
	assign full[5] = CUR_REL[CW-1:0];
	assign full[6] = SC_DET[CW-1:0];                    // R24
	assign full[7] = XC_DET[CW-1:0];
	assign full[8] = XC_REL[CW-1:0];

	wire [NT-1:0] fire;
	genvar g;
	generate
		for (g = 0; g < NT; g = g + 1) begin : g_tmr
			reg  [CW-1:0] cnt;
			wire [CW-1:0] lim;
			// short-circuit delay is analog, not shortened
			assign lim = (g == 6) ? full[g] : term(full[g], shorten); // R21 R22 R26
			assign fire[g] = cond[g] & (cnt >= lim - 1'b1);
			always @(posedge core_clk or posedge rst) begin
				if (rst)
					cnt <= {CW{1'b0}};
				else if (!cond[g] || fire[g])
					cnt <= {CW{1'b0}};          // R25 R17
				else
					cnt <= cnt + 1'b1;
			end
		end
	endgenerate

	always @(posedge core_clk or posedge rst) begin
		if (rst) begin
			oc_st      <= 1'b0;
			od_st      <= 1'b0;
			cur_st     <= 1'b0;
			sc_st      <= 1'b0;
			xc_st      <= 1'b0;
			standby    <= 1'b0;
			zero_armed <= 1'b0;
		end else begin
			zero_armed <= s_zero;               // R20
			if (fire[0])
				oc_st <= 1'b1;                  // R1
			else if (fire[1])
				oc_st <= 1'b0;                  // R4 R5
			if (fire[2]) begin
				od_st   <= 1'b1;                // R7
				standby <= 1'b1;                // R8
				cur_st  <= 1'b0;
			end else if (fire[3])
				od_st <= 1'b0;                  // R10
			if (standby && s_stbr)
				standby <= 1'b0;                // R9
			if (fire[4])
				cur_st <= 1'b1;                 // R11
			if (fire[6])
				sc_st <= 1'b1;                  // R13
			if (fire[5]) begin
				cur_st <= 1'b0;                 // R15
				sc_st  <= 1'b0;
			end
			if (fire[7])
				xc_st <= 1'b1;                  // R16
			else if (fire[8] || !xc_eval)
				xc_st <= 1'b0;                  // R18
		end
	end

	// gate and pull outputs, registered
	always @(posedge core_clk or posedge rst) begin
		if (rst) begin
			charge_gate    <= 1'b0;
			discharge_gate <= 1'b1;
			pull_to_vdd    <= 1'b0;
			pull_to_vss    <= 1'b0;
			hyst_cancel    <= 1'b0;
		end else begin
			charge_gate    <= (~oc_st & ~xc_st) | (zero_armed & ~oc_st); // R6 R20
			discharge_gate <= ~od_st & ~cur_st & ~sc_st;  // R7 R11 R13
			pull_to_vdd    <= od_st;                      // R8
			pull_to_vss    <= (cur_st | sc_st) & ~od_st;  // R12 R14
			hyst_cancel    <= oc_st & s_load;             // R2
		end
	end

	// avalon slave: one wait cycle, answer on second cycle
	reg ack;
	assign avs_waitrequest = (avs_read | avs_write) & ~ack;
	always @(posedge core_clk or posedge rst) begin
		if (rst) begin
			ack          <= 1'b0;
			ctrl_shorten <= 1'b0;
			avs_readdata <= 32'h00000000;
		end else begin
			ack <= (avs_read | avs_write) & ~ack;
			if (avs_write && !ack && avs_address == `BPF_ADDR_CTRL)
				ctrl_shorten <= avs_writedata[`BPF_CT_SHORTEN];
			if (avs_read && !ack) begin
				case (avs_address)
				`BPF_ADDR_CTRL:
					avs_readdata <= {31'h0, ctrl_shorten};
				`BPF_ADDR_STATUS:
					avs_readdata <= {21'h0, shorten, pull_to_vss,
						pull_to_vdd, standby, xc_st, sc_st, cur_st,
						od_st, oc_st, discharge_gate, charge_gate};
				`BPF_ADDR_INPUTS:
					avs_readdata <= {18'h0, sync2};
				`BPF_ADDR_ID:
					avs_readdata <= `BPF_ID_VALUE;
				default:
					avs_readdata <= 32'h00000000;
				endcase
			end
		end
	end

endmodule // bpf_protect

`default_nettype wire

/* tb/bpf_fet_model.sv */
`timescale 1ns/10ps
`default_nettype none
module bpf_fet_model (
	input  wire logic charge_gate,
	input  wire logic discharge_gate,
	output wire logic chg_on,
	output wire logic dsg_on
);
	// n-channel switches conduct while the gate is high
	assign chg_on = charge_gate;
	assign dsg_on = discharge_gate;
endmodule // bpf_fet_model
`default_nettype wire

/* tb/bpf_protect_asserts.sv */
`timescale 1ns/10ps
`default_nettype none
module bpf_protect_chk #(
	parameter SC_DET = 64
) (
	input wire logic       core_clk,
	input wire logic       rst,
	input wire logic [1:0] cell_overcharge,
	input wire logic [1:0] cell_overdischarge,
	input wire logic       overcurrent_threshold,
	input wire logic       short_circuit,
	input wire logic       excess_charger,
	input wire logic       standby_release,
	input wire logic       charge_gate,
	input wire logic       discharge_gate,
	input wire logic       pull_to_vdd,
	input wire logic       pull_to_vss,
	input wire logic       standby
);
	wire       flt = |cell_overdischarge | overcurrent_threshold | short_circuit;
	reg [15:0] sc_run;
	always @(posedge core_clk or posedge rst)
		if (rst) sc_run <= 16'h0;
		else sc_run <= short_circuit ? sc_run + 16'h1 : 16'h0;
	default clocking @(posedge core_clk); endclocking
	default disable iff (rst);
	a_stby_pull: assert property ($past(standby) |-> pull_to_vdd && !pull_to_vss)
		else $error("stand-by without supply pull");
	a_gnd_nostby: assert property (pull_to_vss |-> !standby)
		else $error("ground pull while in stand-by");
	a_stby_dsg: assert property ($past(standby) |-> !discharge_gate)
		else $error("discharge gate high in stand-by");
	a_dsg_cause: assert property ($fell(discharge_gate) |-> $past(flt, 3))
		else $error("discharge gate fell without cause");
	a_dsg_back: assert property ($rose(discharge_gate) |-> $past(!flt, 3))
		else $error("discharge gate rose during fault");
	a_chg_cause: assert property ($fell(charge_gate)
		|-> $past(|cell_overcharge || excess_charger, 3))
		else $error("charge gate fell without cause");
	a_wake_cause: assert property ($fell(standby) |-> $past(standby_release, 3))
		else $error("stand-by left without charger");
	a_sc_late: assert property (sc_run == SC_DET + 6 |-> !discharge_gate)
		else $error("short circuit not acted on");
	a_sc_noshort: assert property (sc_run == 16'd4 && discharge_gate
		&& !overcurrent_threshold |-> discharge_gate [*8])
		else $error("short delay was shortened");
	cover property ($fell(discharge_gate));
	cover property ($rose(standby));
	cover property ($rose(pull_to_vss));
	cover property ($fell(charge_gate));
endmodule // bpf_protect_chk
bind bpf_protect bpf_protect_chk #(.SC_DET(SC_DET)) u_chk (
	.core_clk(core_clk), .rst(rst), .cell_overcharge(cell_overcharge),
	.cell_overdischarge(cell_overdischarge), .short_circuit(short_circuit),
	.overcurrent_threshold(overcurrent_threshold), .standby(standby),
	.excess_charger(excess_charger), .standby_release(standby_release),
	.charge_gate(charge_gate), .discharge_gate(discharge_gate),
	.pull_to_vdd(pull_to_vdd), .pull_to_vss(pull_to_vss));
`default_nettype wire

/* tb/tb_two_cell_battery_protect_fsm.sv */
`timescale 1ns/10ps
`default_nettype none
`include "bpf_defines.vh"
module tb_two_cell_battery_protect_fsm;
	localparam int OD = 200, CUR = 100, SC = 64, XC = 60, OC = 60;
	logic        core_clk = 0, rst = 1;
	logic [1:0]  ovc = 0, ocr = 0, ovd = 0;
	logic        lnl = 0, lat = 0, oct = 0, scir = 0, xch = 0;
	logic        sbr = 0, zvo = 0, shp = 0, rd = 0, wr = 0;
	logic [3:0]  adr = 0;
	logic [31:0] wd = 0;
	wire  [31:0] rdat;
	wire         wreq, cg, dg, pv, ps, sb, hc, con, don;
	logic [63:0] q[$];
	logic [63:0] n;
	int          error_cnt = 0, checks = 0;
	bpf_protect #(.SHORT_DIV(4), .OC_DET(OC), .OC_REL(OC), .OD_DET(OD),
		.OD_REL(60), .CUR_DET(CUR), .CUR_REL(40), .SC_DET(SC),
		.XC_DET(XC), .XC_REL(XC)) dut_u (
		.core_clk(core_clk), .rst(rst), .cell_overcharge(ovc),
		.cell_oc_release(ocr), .cell_overdischarge(ovd),
		.load_node_level(lnl), .load_attached(lat),
		.overcurrent_threshold(oct), .short_circuit(scir),
		.excess_charger(xch), .standby_release(sbr), .zero_volt_ok(zvo),
		.shorten_pin(shp), .avs_address(adr), .avs_read(rd),
		.avs_write(wr), .avs_writedata(wd), .avs_readdata(rdat),
		.avs_waitrequest(wreq), .charge_gate(cg), .discharge_gate(dg),
		.pull_to_vdd(pv), .pull_to_vss(ps), .standby(sb),
		.hyst_cancel(hc));
	bpf_fet_model fet_u (.charge_gate(cg), .discharge_gate(dg),
		.chg_on(con), .dsg_on(don));
	always #4 core_clk = ~core_clk;
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("[ERR] readdata exp %h seen %h", exp, seen);
		end
	endtask
	task stop_test;
		$display("checks %0d error_cnt %0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task wt(input int c);
		repeat (c) @(posedge core_clk);
	endtask
	task bus(input logic w, input logic [3:0] a,
		input logic [31:0] d, input logic [31:0] m, input logic [31:0] e);
		logic wq;
		if (!w) q.push_back({m, e});
		adr <= a; wd <= d; rd <= !w; wr <= w;
		// waitrequest is looked at settled, then the edge is taken
		do begin
			@(negedge core_clk);
			wq = wreq;
			@(posedge core_clk);
		end while (wq);
		rd <= 0; wr <= 0;
		@(posedge core_clk);
	endtask
	task st(input logic [31:0] m, input logic [31:0] e);
		bus(0, `BPF_ADDR_STATUS, 0, m, e);
	endtask
	// compare read data at the edge that takes the read
	always @(posedge core_clk) if (rd && !wreq) begin
		n = q.pop_front();
		chk(rdat & n[63:32], n[31:0]);
	end
	initial begin
		#(8 * 12000);
		error_cnt++;
		stop_test();
	end
	initial begin
		void'($urandom(42639));
		wt(10); rst <= 0; zvo <= 1; wt(30);
		bus(0, `BPF_ADDR_ID, 0, '1, `BPF_ID_VALUE);
		bus(1, 4'h6, $urandom, 0, 0);
		bus(0, 4'h6, 0, '1, 0);
		st(32'h3, 32'h3);
		zvo <= 0;
		ovc <= 2'b01; wt(OC + 10); st(32'h5, 32'h4);
		lat <= 1; wt(5);
		chk(hc, 32'h1);
		lat <= 0; wt(5);
		chk(hc, 32'h0);
		oct <= 1; wt(CUR + 10); st(32'h17, 32'h6);
		oct <= 0; ovc <= 0; ocr <= 2'b11; wt(OC + 10);
		st(32'h5, 32'h1);
		ovd <= 2'b10; wt(OD + 10); st(32'h18a, 32'h188);
		chk({con, don}, 32'h2);
		ovd <= 0; wt(80); st(32'h82, 32'h80);
		sbr <= 1; wt(80); st(32'h82, 32'h2);
		sbr <= 0; shp <= 1; oct <= 1; wt(CUR / 4 + 12);
		st(32'h292, 32'h210);
		oct <= 0; wt(25); st(32'h212, 32'h2);
		scir <= 1; wt(SC / 4 + 6); st(32'h2, 32'h2);
		wt(SC); st(32'h2a2, 32'h220);
		scir <= 0; wt(25); st(32'h22, 32'h2);
		shp <= 0; xch <= 1; wt(XC / 2); xch <= 0; wt(XC);
		st(32'h41, 32'h1);
		xch <= 1; wt(XC + 10); st(32'h41, 32'h40);
		xch <= 0; wt(XC + 10); st(32'h41, 32'h1);
		oct <= 1; wt(CUR + 10); xch <= 1; wt(XC + 10);
		st(32'h43, 32'h1);
		oct <= 0; wt(XC + 60); st(32'h43, 32'h42);
		xch <= 0; wt(XC + 10);
		stop_test();
	end
endmodule // tb_two_cell_battery_protect_fsm
`default_nettype wire
